// [src/sbc_params.svh]
// timing, field and command-code constants for the sdram bank command tracker
`ifndef SBC_PARAMS_SVH
`define SBC_PARAMS_SVH

// ---------------------------------------------------------------
// clock and counter sizing
// ---------------------------------------------------------------
`define SBC_CLK_PS        5000
`define SBC_CNT_W         8
`define SBC_NUM_BANKS     4
`define SBC_ADDR_W        13

// ---------------------------------------------------------------
// timing figures in ns, and cycle counts rounded up
// ---------------------------------------------------------------
`define SBC_CYC(ns)       ((((ns) * 1000) + `SBC_CLK_PS - 1) / `SBC_CLK_PS)
`define SBC_PRECHARGE_NS  20
`define SBC_ACTIVATE_NS   20
`define SBC_REFRESH_NS    70
`define SBC_MODE_LOAD_NS  10
`define SBC_SR_EXIT_NS    75
`define SBC_PRECHARGE_CYC `SBC_CYC(`SBC_PRECHARGE_NS)
`define SBC_ACTIVATE_CYC  `SBC_CYC(`SBC_ACTIVATE_NS)
`define SBC_REFRESH_CYC   `SBC_CYC(`SBC_REFRESH_NS)
`define SBC_MODE_LOAD_CYC `SBC_CYC(`SBC_MODE_LOAD_NS)
`define SBC_SR_EXIT_CYC   `SBC_CYC(`SBC_SR_EXIT_NS)

// ---------------------------------------------------------------
// address field and {row, column, write} strobe codes (low = 0)
// ---------------------------------------------------------------
`define SBC_AP_BIT        10
`define SBC_CMD_LMR       3'h0
`define SBC_CMD_REF       3'h1
`define SBC_CMD_PRE       3'h2
`define SBC_CMD_ACT       3'h3
`define SBC_CMD_WR        3'h4
`define SBC_CMD_RD        3'h5
`define SBC_CMD_TERM      3'h6
`define SBC_CMD_NOP       3'h7

`endif

// [src/sbc_pkg.sv]
// shared types for the sdram bank command tracker
package sbc_pkg;

  // per-bank state
  typedef enum logic [2:0] {
    BK_IDLE, BK_ACTIVATING, BK_ACTIVE, BK_READ, BK_WRITE,
    BK_READ_AP, BK_WRITE_AP, BK_PRECHARGING
  } sbc_bank_e;

  // command steered to one bank after legality checks
  typedef enum logic [2:0] {
    BC_NONE, BC_ACT, BC_RD, BC_WR, BC_RD_AP, BC_WR_AP, BC_PRE, BC_TERM
  } sbc_bcmd_e;

  // device-wide state; every state but DV_NORMAL is timed and locks out every bank
  typedef enum logic [1:0] {
    DV_NORMAL, DV_REFRESH, DV_MODE, DV_PRE_ALL
  } sbc_dev_e;

endpackage

// [src/sbc_bank_fsm.sv]
// one bank: state register plus its own timing down-counter
`timescale 1ns/1ps
`include "sbc_params.svh"

module sbc_bank_fsm #(
  parameter int               CNT_W   = `SBC_CNT_W,
  parameter logic [CNT_W-1:0] PRE_CYC = CNT_W'(`SBC_PRECHARGE_CYC),
  parameter logic [CNT_W-1:0] ACT_CYC = CNT_W'(`SBC_ACTIVATE_CYC)
) (
  input  wire logic               core_clk_in,
  input  wire logic               sys_rst_in,
  input  wire sbc_pkg::sbc_bcmd_e cmd_in,
  output sbc_pkg::sbc_bank_e      state_out
);

  typedef struct packed {
    sbc_pkg::sbc_bank_e st;
    logic [CNT_W-1:0]   cnt;
  } sbc_bank_s;

  sbc_bank_s s_reg;
  sbc_bank_s s_next;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  // accepted commands win over timer expiry; the top never sends a command
  // to a bank in a timed state, so the two cannot collide here
  always_comb begin
    s_next = s_reg;
    if (s_reg.cnt != '0) begin
      s_next.cnt = s_reg.cnt - CNT_W'(1);
    end
    case (cmd_in)
      sbc_pkg::BC_ACT: begin
        s_next.st  = sbc_pkg::BK_ACTIVATING;
        s_next.cnt = ACT_CYC;
      end
      sbc_pkg::BC_RD: s_next.st = sbc_pkg::BK_READ;
      sbc_pkg::BC_WR: s_next.st = sbc_pkg::BK_WRITE;
      sbc_pkg::BC_RD_AP: begin
        s_next.st  = sbc_pkg::BK_READ_AP;
        s_next.cnt = PRE_CYC;
      end
      sbc_pkg::BC_WR_AP: begin
        s_next.st  = sbc_pkg::BK_WRITE_AP;
        s_next.cnt = PRE_CYC;
      end
      sbc_pkg::BC_PRE: begin
        // an idle bank ignores it; open banks and bursts are cut off
        if (s_reg.st != sbc_pkg::BK_IDLE) begin
          s_next.st  = sbc_pkg::BK_PRECHARGING;
          s_next.cnt = PRE_CYC;
        end
      end
      sbc_pkg::BC_TERM: begin
        if (s_reg.st == sbc_pkg::BK_READ || s_reg.st == sbc_pkg::BK_WRITE) begin
          s_next.st = sbc_pkg::BK_ACTIVE;
        end
      end
      default: begin
        if (s_reg.cnt == CNT_W'(1)) begin
          case (s_reg.st)
            sbc_pkg::BK_ACTIVATING:  s_next.st = sbc_pkg::BK_ACTIVE;
            sbc_pkg::BK_PRECHARGING: s_next.st = sbc_pkg::BK_IDLE;
            sbc_pkg::BK_READ_AP:     s_next.st = sbc_pkg::BK_IDLE;
            sbc_pkg::BK_WRITE_AP:    s_next.st = sbc_pkg::BK_IDLE;
            default:                 s_next.st = s_reg.st;
          endcase
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s_reg <= '{st: sbc_pkg::BK_IDLE, cnt: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign state_out = s_reg.st;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  act_enter_a:
    assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      cmd_in == sbc_pkg::BC_ACT |=>
        s_reg.st == sbc_pkg::BK_ACTIVATING && s_reg.cnt == ACT_CYC)
      else $error("activate did not start row activation");
  act_done_a:
    assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      s_reg.st == sbc_pkg::BK_ACTIVATING && s_reg.cnt == CNT_W'(1) |=>
        s_reg.st == sbc_pkg::BK_ACTIVE)
      else $error("row activation did not end in row active");
  pre_idle_a:
    assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      cmd_in == sbc_pkg::BC_PRE && s_reg.st == sbc_pkg::BK_IDLE |=>
        s_reg.st == sbc_pkg::BK_IDLE && $stable(s_reg.cnt))
      else $error("precharge changed an idle bank");
  read_start_a:
    assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      cmd_in == sbc_pkg::BC_RD |=> s_reg.st == sbc_pkg::BK_READ)
      else $error("read did not start a read burst");
  write_start_a:
    assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      cmd_in == sbc_pkg::BC_WR |=> s_reg.st == sbc_pkg::BK_WRITE)
      else $error("write did not start a write burst");
  burst_cut_a:
    assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      cmd_in == sbc_pkg::BC_PRE &&
      (s_reg.st == sbc_pkg::BK_READ || s_reg.st == sbc_pkg::BK_WRITE) |=>
        s_reg.st == sbc_pkg::BK_PRECHARGING && s_reg.cnt == PRE_CYC)
      else $error("precharge did not cut the burst");
  pre_done_a:
    assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      s_reg.st == sbc_pkg::BK_PRECHARGING && s_reg.cnt == CNT_W'(1) |=>
        s_reg.st == sbc_pkg::BK_IDLE)
      else $error("precharge did not end in idle");
  ap_hold_a:
    assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      (cmd_in == sbc_pkg::BC_RD_AP || cmd_in == sbc_pkg::BC_WR_AP) |=>
        s_reg.cnt == PRE_CYC ##(PRE_CYC) s_reg.st == sbc_pkg::BK_IDLE)
      else $error("auto precharge hold time wrong");

endmodule

// [src/sbc_cmd_state.sv]
// command decode and per-bank state tracking for a four-bank sdram
`timescale 1ns/1ps
`include "sbc_params.svh"

module sbc_cmd_state #(
  parameter int               NB       = `SBC_NUM_BANKS,
  parameter int               ADDR_W   = `SBC_ADDR_W,
  parameter int               CNT_W    = `SBC_CNT_W,
  parameter logic [CNT_W-1:0] PRE_CYC  = CNT_W'(`SBC_PRECHARGE_CYC),
  parameter logic [CNT_W-1:0] ACT_CYC  = CNT_W'(`SBC_ACTIVATE_CYC),
  parameter logic [CNT_W-1:0] REF_CYC  = CNT_W'(`SBC_REFRESH_CYC),
  parameter logic [CNT_W-1:0] MODE_CYC = CNT_W'(`SBC_MODE_LOAD_CYC),
  parameter logic [CNT_W-1:0] XSR_CYC  = CNT_W'(`SBC_SR_EXIT_CYC)
) (
  input  wire logic                       core_clk_in,
  input  wire logic                       sys_rst_in,
  input  wire logic                       cke_in,
  input  wire logic                       cs_n_in,
  input  wire logic                       ras_n_in,
  input  wire logic                       cas_n_in,
  input  wire logic                       we_n_in,
  input  wire logic [$clog2(NB)-1:0]      ba_in,
  input  wire logic [ADDR_W-1:0]          addr_in,
  output sbc_pkg::sbc_bank_e [NB-1:0]     bank_state_out,
  output sbc_pkg::sbc_dev_e               dev_state_out,
  output logic                            cmd_accept_out,
  output logic                            cmd_illegal_out,
  output logic [$clog2(NB)-1:0]           burst_bank_out,
  output logic                            burst_open_out
);

  localparam int BA_W = $clog2(NB);

  typedef struct packed {
    logic               cke_prev;
    logic [CNT_W-1:0]   xsr_cnt;
    sbc_pkg::sbc_dev_e  dev;
    logic [CNT_W-1:0]   dev_cnt;
    logic [BA_W-1:0]    last_bank;
    logic               accept;
    logic               illegal;
  } sbc_top_s;

  sbc_top_s           s_reg;
  sbc_top_s           s_next;
  sbc_pkg::sbc_bcmd_e bcmd [NB];
  logic [2:0]         cmd_code;
  logic               decode_en;
  logic               exec_cmd;
  logic               all_idle;
  logic               pre_all_ok;
  logic               auto_pre;

  // ---------------------------------------------------------------
  // state classification helpers
  // ---------------------------------------------------------------
  // a bank with an open row that takes reads, writes and precharge
  function automatic logic sbc_open(input sbc_pkg::sbc_bank_e st);
    return st == sbc_pkg::BK_ACTIVE || st == sbc_pkg::BK_READ ||
           st == sbc_pkg::BK_WRITE;
  endfunction

  // a bank from which a precharge is allowed
  function automatic logic sbc_pre_ok(input sbc_pkg::sbc_bank_e st);
    return st == sbc_pkg::BK_IDLE || sbc_open(st);
  endfunction

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  assign cmd_code = {ras_n_in, cas_n_in, we_n_in};
  assign auto_pre = addr_in[`SBC_AP_BIT];
  // clock enable must be high on this and the previous edge, and any
  // exit wait after clock enable came back must have run out
  assign decode_en = s_reg.cke_prev && cke_in && s_reg.xsr_cnt == '0;
  // inhibit and no-operation never reach the banks
  assign exec_cmd = decode_en && !cs_n_in && cmd_code != `SBC_CMD_NOP;

  // whole-device conditions
  always_comb begin
    all_idle   = 1'b1;
    pre_all_ok = 1'b1;
    for (int i = 0; i < NB; i++) begin
      if (bank_state_out[i] != sbc_pkg::BK_IDLE) begin
        all_idle = 1'b0;
      end
      if (!sbc_pre_ok(bank_state_out[i])) begin
        pre_all_ok = 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // next state and bank steering
  // ---------------------------------------------------------------
  // an illegal request is refused whole: no bank moves and the refusal
  // shows one cycle later, so a misbehaving controller is visible
  always_comb begin
    s_next          = s_reg;
    s_next.accept   = 1'b0;
    s_next.illegal  = 1'b0;
    s_next.cke_prev = cke_in;
    for (int i = 0; i < NB; i++) begin
      bcmd[i] = sbc_pkg::BC_NONE;
    end
    // exit from a low-power spell restarts the wait before decoding
    if (!s_reg.cke_prev && cke_in) begin
      s_next.xsr_cnt = XSR_CYC;
    end else if (s_reg.xsr_cnt != '0) begin
      s_next.xsr_cnt = s_reg.xsr_cnt - CNT_W'(1);
    end
    // device-wide timed states count down to all banks idle
    if (s_reg.dev_cnt != '0) begin
      s_next.dev_cnt = s_reg.dev_cnt - CNT_W'(1);
      if (s_reg.dev_cnt == CNT_W'(1)) begin
        s_next.dev = sbc_pkg::DV_NORMAL;
      end
    end
    if (exec_cmd) begin
      if (s_reg.dev != sbc_pkg::DV_NORMAL) begin
        s_next.illegal = 1'b1;
      end else begin
        case (cmd_code)
          `SBC_CMD_ACT: begin
            // other banks never block this bank
            if (bank_state_out[ba_in] == sbc_pkg::BK_IDLE) begin
              bcmd[ba_in]   = sbc_pkg::BC_ACT;
              s_next.accept = 1'b1;
            end else begin
              s_next.illegal = 1'b1;
            end
          end
          `SBC_CMD_RD, `SBC_CMD_WR: begin
            if (sbc_open(bank_state_out[ba_in])) begin
              if (cmd_code == `SBC_CMD_RD) begin
                bcmd[ba_in] = auto_pre ? sbc_pkg::BC_RD_AP : sbc_pkg::BC_RD;
              end else begin
                bcmd[ba_in] = auto_pre ? sbc_pkg::BC_WR_AP : sbc_pkg::BC_WR;
              end
              s_next.last_bank = ba_in;
              s_next.accept    = 1'b1;
            end else begin
              s_next.illegal = 1'b1;
            end
          end
          `SBC_CMD_PRE: begin
            if (auto_pre) begin
              // bank select ignored; every bank must be fit to precharge
              if (pre_all_ok) begin
                for (int i = 0; i < NB; i++) begin
                  bcmd[i] = sbc_pkg::BC_PRE;
                end
                s_next.dev     = sbc_pkg::DV_PRE_ALL;
                s_next.dev_cnt = PRE_CYC;
                s_next.accept  = 1'b1;
              end else begin
                s_next.illegal = 1'b1;
              end
            end else if (sbc_pre_ok(bank_state_out[ba_in])) begin
              bcmd[ba_in]   = sbc_pkg::BC_PRE;
              s_next.accept = 1'b1;
            end else begin
              s_next.illegal = 1'b1;
            end
          end
          `SBC_CMD_REF: begin
            if (all_idle) begin
              s_next.dev     = sbc_pkg::DV_REFRESH;
              s_next.dev_cnt = REF_CYC;
              s_next.accept  = 1'b1;
            end else begin
              s_next.illegal = 1'b1;
            end
          end
          `SBC_CMD_LMR: begin
            if (all_idle) begin
              s_next.dev     = sbc_pkg::DV_MODE;
              s_next.dev_cnt = MODE_CYC;
              s_next.accept  = 1'b1;
            end else begin
              s_next.illegal = 1'b1;
            end
          end
          `SBC_CMD_TERM: begin
            // only a burst without auto precharge can be cut short
            if (burst_open_out) begin
              bcmd[s_reg.last_bank] = sbc_pkg::BC_TERM;
              s_next.accept         = 1'b1;
            end else begin
              s_next.illegal = 1'b1;
            end
          end
          default: s_next.illegal = 1'b1;
        endcase
      end
    end
  end

  // state register
  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s_reg <= '{cke_prev: 1'b1, xsr_cnt: '0, dev: sbc_pkg::DV_NORMAL,
                 dev_cnt: '0, last_bank: '0, accept: 1'b0, illegal: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  // ---------------------------------------------------------------
  // banks
  // ---------------------------------------------------------------
  // each bank times itself so bank activity overlaps freely
  for (genvar g = 0; g < NB; g++) begin : gen_bank
    sbc_bank_fsm #(
      .CNT_W   (CNT_W),
      .PRE_CYC (PRE_CYC),
      .ACT_CYC (ACT_CYC)
    ) u_bank (
      .core_clk_in (core_clk_in),
      .sys_rst_in  (sys_rst_in),
      .cmd_in      (bcmd[g]),
      .state_out   (bank_state_out[g])
    );
  end

  // outputs
  assign dev_state_out   = s_reg.dev;
  assign cmd_accept_out  = s_reg.accept;
  assign cmd_illegal_out = s_reg.illegal;
  assign burst_bank_out  = s_reg.last_bank;
  assign burst_open_out  = bank_state_out[s_reg.last_bank] == sbc_pkg::BK_READ ||
                           bank_state_out[s_reg.last_bank] == sbc_pkg::BK_WRITE;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  inhibit_quiet_a:
    assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      cs_n_in |=> !cmd_accept_out && !cmd_illegal_out)
      else $error("inhibit cycle was decoded");
  nop_quiet_a:
    assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      !cs_n_in && cmd_code == `SBC_CMD_NOP |=> !cmd_accept_out && !cmd_illegal_out)
      else $error("no-operation was decoded");
  mode_lock_a:
    assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      exec_cmd && cmd_code == `SBC_CMD_LMR && all_idle &&
      s_reg.dev == sbc_pkg::DV_NORMAL |=>
        dev_state_out == sbc_pkg::DV_MODE ##(MODE_CYC) dev_state_out == sbc_pkg::DV_NORMAL)
      else $error("mode access lock length wrong");
  refresh_lock_a:
    assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      exec_cmd && cmd_code == `SBC_CMD_REF && all_idle &&
      s_reg.dev == sbc_pkg::DV_NORMAL |=>
        dev_state_out == sbc_pkg::DV_REFRESH ##(REF_CYC) dev_state_out == sbc_pkg::DV_NORMAL)
      else $error("refresh lock length wrong");
  busy_refuse_a:
    assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      exec_cmd && s_reg.dev != sbc_pkg::DV_NORMAL |=> cmd_illegal_out && !cmd_accept_out)
      else $error("command taken during device lock");
  pre_all_a:
    assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      exec_cmd && cmd_code == `SBC_CMD_PRE && auto_pre && pre_all_ok &&
      s_reg.dev == sbc_pkg::DV_NORMAL |=>
        dev_state_out == sbc_pkg::DV_PRE_ALL && !burst_open_out)
      else $error("precharge all not applied");
  cke_gate_a:
    assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      !cke_in |=> !cmd_accept_out [*2])
      else $error("decoded with clock enable low");
  term_cut_a:
    assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
      exec_cmd && cmd_code == `SBC_CMD_TERM && burst_open_out &&
      s_reg.dev == sbc_pkg::DV_NORMAL |=>
        bank_state_out[$past(s_reg.last_bank)] == sbc_pkg::BK_ACTIVE)
      else $error("burst terminate missed latest burst");

  refresh_c: cover property (@(posedge core_clk_in) disable iff (sys_rst_in)
    dev_state_out == sbc_pkg::DV_REFRESH ##[1:40] dev_state_out == sbc_pkg::DV_NORMAL);
  pre_all_c: cover property (@(posedge core_clk_in) disable iff (sys_rst_in)
    dev_state_out == sbc_pkg::DV_PRE_ALL);
  act_read_c: cover property (@(posedge core_clk_in) disable iff (sys_rst_in)
    bank_state_out[0] == sbc_pkg::BK_ACTIVATING ##[1:20] bank_state_out[0] == sbc_pkg::BK_READ);
  two_bank_c: cover property (@(posedge core_clk_in) disable iff (sys_rst_in)
    bank_state_out[0] == sbc_pkg::BK_READ && bank_state_out[1] == sbc_pkg::BK_WRITE_AP);

endmodule

// [dv/sbc_ctl_model.sv]
// controller model that issues sdram commands to the bank tracker
`timescale 1ns/1ps

module sbc_ctl_model (
  input  wire logic        core_clk_in,
  output logic             cke_out,
  output logic             cs_n_out,
  output logic [2:0]       cmd_out,
  output logic [1:0]       ba_out,
  output logic [12:0]      addr_out
);
  // the device comes out of reset deselected with clock enable high
  initial begin
    cke_out  = 1'b1;
    cs_n_out = 1'b1;
    cmd_out  = 3'h7;
    ba_out   = 2'h0;
    addr_out = 13'h0000;
  end

  // one command per edge; lockout spacing is left to the caller
  task automatic send(input logic [2:0] c, input logic [1:0] b, input logic [12:0] a);
    @(posedge core_clk_in);
    cs_n_out <= 1'b0;
    cmd_out  <= c;
    ba_out   <= b;
    addr_out <= a;
  endtask

  // deselected lines keep toggling, so a decoder peeking at them shows up
  task automatic idle(input int n, input logic [31:0] r);
    repeat (n) begin
      @(posedge core_clk_in);
      cs_n_out <= 1'b1;
      cmd_out  <= r[2:0];
      ba_out   <= r[4:3];
      addr_out <= r[17:5];
      r        = ~r;
    end
  endtask

  // clock enable changes only with the device deselected
  task automatic cke(input logic v);
    @(posedge core_clk_in);
    cke_out  <= v;
    cs_n_out <= 1'b1;
  endtask
endmodule

// [dv/sbc_cmd_state_tb.sv]
// self-checking bench for the sdram bank command tracker
`timescale 1ns/1ps
`include "sbc_params.svh"

module sbc_cmd_state_tb;
  // short timings keep the run brief; every expectation but the reset at(3) idle check and the final at(4) activation wait uses these
  localparam logic [7:0] PRE = 8'h03;
  localparam logic [7:0] ACT = 8'h02;
  localparam logic [7:0] REF = 8'h05;
  localparam logic [7:0] MDL = 8'h02;
  localparam logic [7:0] XSR = 8'h04;
  logic                      core_clk_in = 1'b0;
  logic                      sys_rst_in  = 1'b1;
  logic                      cke, cs_n;
  logic [2:0]                cmd;
  logic [1:0]                ba, burst_bank_out;
  logic [12:0]               addr;
  sbc_pkg::sbc_bank_e [3:0]  bank_state_out;
  sbc_pkg::sbc_dev_e         dev_state_out;
  logic                      cmd_accept_out, cmd_illegal_out, burst_open_out;
  logic [31:0]               seed = 32'h2f2c;
  logic [5:0]                q[$];
  int                        n_errors = 0;
  int                        cmp_count = 0;
  // expected timed states per loop pass, kept as typed tables to avoid enum casts
  sbc_pkg::sbc_bank_e        ap_st [2] = '{sbc_pkg::BK_READ_AP, sbc_pkg::BK_WRITE_AP};
  sbc_pkg::sbc_dev_e         lk_st [2] = '{sbc_pkg::DV_REFRESH, sbc_pkg::DV_MODE};

  always #2.5 core_clk_in = ~core_clk_in;

  sbc_ctl_model u_ctl (.core_clk_in(core_clk_in), .cke_out(cke), .cs_n_out(cs_n),
    .cmd_out(cmd), .ba_out(ba), .addr_out(addr));
  sbc_cmd_state #(.PRE_CYC(PRE), .ACT_CYC(ACT), .REF_CYC(REF), .MODE_CYC(MDL),
    .XSR_CYC(XSR)) u_dut (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
    .cke_in(cke), .cs_n_in(cs_n), .ras_n_in(cmd[2]), .cas_n_in(cmd[1]),
    .we_n_in(cmd[0]), .ba_in(ba), .addr_in(addr), .bank_state_out(bank_state_out),
    .dev_state_out(dev_state_out), .cmd_accept_out(cmd_accept_out),
    .cmd_illegal_out(cmd_illegal_out), .burst_bank_out(burst_bank_out),
    .burst_open_out(burst_open_out));

  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // random row/column bits, with the auto precharge bit forced
  function logic [12:0] ad(input logic ap);
    ad              = 13'(rnd());
    ad[`SBC_AP_BIT] = ap;
  endfunction
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // note the answer and the bank state it leaves, then issue the command
  task automatic op(input logic [2:0] c, input logic [1:0] b, input logic [12:0] a,
                    input logic acc, input sbc_pkg::sbc_bank_e st);
    q.push_back({acc, b, st});
    u_ctl.send(c, b, a);
  endtask
  // idle n edges, then check one bank and the device state
  task automatic at(input int n, input logic [1:0] b, input sbc_pkg::sbc_bank_e st,
                    input sbc_pkg::sbc_dev_e d);
    u_ctl.idle(n, rnd());
    @(negedge core_clk_in);
    chk("bank", 8'(bank_state_out[b]), 8'(st));
    chk("dev", 8'(dev_state_out), 8'(d));
  endtask
  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // any pulse is matched to the oldest note; a pulse with none noted is wrong
  always @(negedge core_clk_in) begin
    logic [5:0] e;
    if (cmd_accept_out === 1'b1 || cmd_illegal_out === 1'b1) begin
      if (q.size() == 0) chk("pulse", 8'h01, 8'h00);
      else begin
        e = q.pop_front();
        // exactly one of accept and refuse may pulse
        chk("answer", {6'h0, cmd_accept_out, cmd_illegal_out}, {6'h0, e[5], !e[5]});
        chk("state", 8'(bank_state_out[e[4:3]]), {5'h0, e[2:0]});
      end
    end
  end

  // a hang is cut short and counted
  initial begin
    repeat (3000) @(posedge core_clk_in);
    chk("timeout", 8'h01, 8'h00);
    results();
  end

  initial begin
    repeat (16) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    at(3, 2'h0, sbc_pkg::BK_IDLE, sbc_pkg::DV_NORMAL);
    u_ctl.send(`SBC_CMD_NOP, 2'h2, ad(1'b0));
    op(`SBC_CMD_PRE, 2'h1, ad(1'b0), 1'b1, sbc_pkg::BK_IDLE);
    op(`SBC_CMD_ACT, 2'h0, ad(1'b0), 1'b1, sbc_pkg::BK_ACTIVATING);
    op(`SBC_CMD_ACT, 2'h1, ad(1'b0), 1'b1, sbc_pkg::BK_ACTIVATING);
    op(`SBC_CMD_RD, 2'h1, ad(1'b0), 1'b0, sbc_pkg::BK_ACTIVATING);
    at(1, 2'h0, sbc_pkg::BK_ACTIVE, sbc_pkg::DV_NORMAL);
    at(1, 2'h1, sbc_pkg::BK_ACTIVE, sbc_pkg::DV_NORMAL);
    op(`SBC_CMD_RD, 2'h0, ad(1'b0), 1'b1, sbc_pkg::BK_READ);
    op(`SBC_CMD_WR, 2'h1, ad(1'b0), 1'b1, sbc_pkg::BK_WRITE);
    op(`SBC_CMD_TERM, 2'h1, ad(1'b0), 1'b1, sbc_pkg::BK_ACTIVE);
    at(1, 2'h0, sbc_pkg::BK_READ, sbc_pkg::DV_NORMAL);
    chk("open", {7'h0, burst_open_out}, 8'h00);
    chk("bbank", {6'h0, burst_bank_out}, 8'h01);
    op(`SBC_CMD_PRE, 2'h0, ad(1'b0), 1'b1, sbc_pkg::BK_PRECHARGING);
    op(`SBC_CMD_WR, 2'h1, ad(1'b0), 1'b1, sbc_pkg::BK_WRITE);
    op(`SBC_CMD_PRE, 2'h1, ad(1'b0), 1'b1, sbc_pkg::BK_PRECHARGING);
    // the taking edge is the first idle edge, so the last precharging look is PRE edges on
    at(PRE, 2'h1, sbc_pkg::BK_PRECHARGING, sbc_pkg::DV_NORMAL);
    at(1, 2'h1, sbc_pkg::BK_IDLE, sbc_pkg::DV_NORMAL);
    // read then write with auto precharge; the bank refuses access meanwhile
    for (int i = 0; i < 2; i++) begin
      op(`SBC_CMD_ACT, 2'h2, ad(1'b0), 1'b1, sbc_pkg::BK_ACTIVATING);
      at(ACT + 1, 2'h2, sbc_pkg::BK_ACTIVE, sbc_pkg::DV_NORMAL);
      op(i ? `SBC_CMD_WR : `SBC_CMD_RD, 2'h2, ad(1'b1), 1'b1, ap_st[i]);
      op(`SBC_CMD_RD, 2'h2, ad(1'b0), 1'b0, ap_st[i]);
      at(PRE - 1, 2'h2, ap_st[i], sbc_pkg::DV_NORMAL);
      at(1, 2'h2, sbc_pkg::BK_IDLE, sbc_pkg::DV_NORMAL);
    end
    // refresh and mode load only with every bank idle, and they lock out commands
    for (int i = 0; i < 2; i++) begin
      op(i ? `SBC_CMD_LMR : `SBC_CMD_REF, 2'h0, ad(1'b0), 1'b1, sbc_pkg::BK_IDLE);
      op(`SBC_CMD_ACT, 2'h3, ad(1'b0), 1'b0, sbc_pkg::BK_IDLE);
      at((i ? MDL : REF) - 1, 2'h3, sbc_pkg::BK_IDLE, lk_st[i]);
      at(1, 2'h3, sbc_pkg::BK_IDLE, sbc_pkg::DV_NORMAL);
    end
    op(`SBC_CMD_ACT, 2'h3, ad(1'b0), 1'b1, sbc_pkg::BK_ACTIVATING);
    at(ACT + 1, 2'h3, sbc_pkg::BK_ACTIVE, sbc_pkg::DV_NORMAL);
    // no burst is open and bank 3 is open, so both are refused with no change
    op(`SBC_CMD_TERM, 2'h3, ad(1'b0), 1'b0, sbc_pkg::BK_ACTIVE);
    op(`SBC_CMD_REF, 2'h3, ad(1'b0), 1'b0, sbc_pkg::BK_ACTIVE);
    // precharge all: the bank bits are random and must be ignored
    q.push_back({1'b1, 2'h3, sbc_pkg::BK_PRECHARGING});
    u_ctl.send(`SBC_CMD_PRE, 2'(rnd()), ad(1'b1));
    at(PRE, 2'h3, sbc_pkg::BK_PRECHARGING, sbc_pkg::DV_PRE_ALL);
    at(1, 2'h3, sbc_pkg::BK_IDLE, sbc_pkg::DV_NORMAL);
    // nothing decodes with clock enable low, nor during the exit wait
    u_ctl.cke(1'b0);
    u_ctl.send(`SBC_CMD_ACT, 2'h0, ad(1'b0));
    u_ctl.cke(1'b1);
    u_ctl.send(`SBC_CMD_ACT, 2'h0, ad(1'b0));
    u_ctl.idle(XSR + 1, rnd());
    op(`SBC_CMD_ACT, 2'h0, ad(1'b0), 1'b1, sbc_pkg::BK_ACTIVATING);
    at(4, 2'h0, sbc_pkg::BK_ACTIVE, sbc_pkg::DV_NORMAL);
    chk("left", 8'(q.size()), 8'h00);
    results();
  end
endmodule
